// File: logic/odf_top.sv
// eight-channel decimation filter core with profile-dependent rates
`include "odf_consts.svh"

module odf_top
   import odf_pkg::*;
(
   // clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 clk_en_i,
   // configuration pins
   input  wire logic [1:0]           profile_select_i,
   input  wire logic                 clock_divide_select_i,
   input  wire logic                 filter_bypass_i,
   input  wire logic                 frame_sync_format_i,
   input  wire logic                 ext_sync_i,
   // modulator streams
   input  wire logic [`ODF_NUM_CH-1:0] mod_bits_i,
   // results towards the serial port
   output logic                      result_valid_o,
   input  wire logic                 result_ready_i,
   output logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] result_data_o,
   // status
   output logic                      mod_strobe_o,
   output logic [`ODF_NUM_CH-1:0]    raw_bits_o,
   output logic                      settled_o,
   output logic                      format_error_o,
   output logic                      overrun_o,
   output logic [1:0]                profile_o
);
   typedef struct packed {
      logic [1:0]                 prof_s1;
      logic [1:0]                 prof_s2;
      logic                       div_s1;
      logic                       div_s2;
      logic                       byp_s1;
      logic                       byp_s2;
      logic                       fs_s1;
      logic                       fs_s2;
      logic                       sync_s1;
      logic                       sync_s2;
      logic                       sync_d;
      logic [`ODF_NUM_CH-1:0]     bits_s1;
      logic [`ODF_NUM_CH-1:0]     bits_s2;
      logic [5:0]                 clk_cnt;
      logic [7:0]                 samp_cnt;
      logic [`ODF_NUM_CH-1:0][`ODF_STAGES-1:0][`ODF_ACC_W-1:0] integ;
      logic [`ODF_NUM_CH-1:0][`ODF_STAGES-1:0][`ODF_ACC_W-1:0] comb_d;
      logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] word_set;
      logic                       word_vld;
      logic [7:0]                 periods;
      logic [1:0]                 last_prof;
      logic                       mod_strobe;
      logic [`ODF_NUM_CH-1:0]     raw_bits;
      logic                       settled;
      logic                       fmt_err;
      logic                       overrun;
      logic                       valid_q;
      logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] data_q;
   } odf_state_t;

   odf_state_t state_ff;
   odf_state_t nxt_state;
   logic       buf_in_ready;
   logic       buf_out_valid;
   logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] buf_out_data;

   // modulator clock divider for a profile and divide pin
   function automatic logic [5:0] mod_div(input logic [1:0] prof,
                                          input logic       div);
      logic [5:0] d;
      d = `ODF_MODDIV_4;
      case (prof)
         `ODF_PROF_LP: d = div ? `ODF_MODDIV_8 : `ODF_MODDIV_4;
         `ODF_PROF_LS: d = div ? `ODF_MODDIV_40 : `ODF_MODDIV_8;
         default:      d = `ODF_MODDIV_4;
      endcase
      return d;
   endfunction

   // oversampling ratio, used for framing; settle time has its own constants
   function automatic logic [7:0] osr(input logic [1:0] prof);
      return (prof == `ODF_PROF_HR) ? `ODF_OSR_128 : `ODF_OSR_64;
   endfunction

   // scale a cic result to 24 bits and clip at full scale
   function automatic logic [`ODF_WORD_W-1:0] clip_word(
      input logic [`ODF_ACC_W-1:0] acc, input logic [1:0] prof);
      odf_acc_t centred;
      odf_acc_t scaled;
      logic [4:0] sh;
      // sinc gain is a power of two: centre on half of it, stretch to 24 bits
      sh = (prof == `ODF_PROF_HR) ? `ODF_SHIFT_128 : `ODF_SHIFT_64;
      centred = $signed(acc) - $signed(`ODF_ACC_W'(1) << (sh - 5'h1));
      scaled  = centred <<< (5'(`ODF_WORD_W) - sh);
      if (scaled > `ODF_ACC_POS_MAX) begin
         return `ODF_POS_FULL;
      end else if (scaled < `ODF_ACC_NEG_MIN) begin
         return `ODF_NEG_FULL;
      end
      return scaled[`ODF_WORD_W-1:0];
   endfunction

   // the two-entry buffer keeps a word set when the serial side stalls
   odf_skid_buf u_buf (
      .sys_clk_i   (sys_clk_i),
      .reset_i     (reset_i),
      .clk_en_i    (clk_en_i),
      .in_valid_i  (state_ff.word_vld),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (state_ff.word_set),
      .out_valid_o (buf_out_valid),
      .out_ready_i (!state_ff.valid_q || result_ready_i),
      .out_data_o  (buf_out_data)
   );

   always_comb begin
      logic                   mod_tick;
      logic                   frame_end;
      logic                   sync_rise;
      logic [`ODF_ACC_W-1:0]  c0;
      logic [`ODF_ACC_W-1:0]  c1;
      logic [`ODF_ACC_W-1:0]  c2;
      logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] words;
      nxt_state = state_ff;
      mod_tick  = 1'b0;
      frame_end = 1'b0;
      sync_rise = 1'b0;
      c0        = '0;
      c1        = '0;
      c2        = '0;
      words     = state_ff.word_set;
      // every configuration pin and modulator bit passes two flops before use; profile monitored always
      nxt_state.prof_s1 = profile_select_i;
      nxt_state.prof_s2 = state_ff.prof_s1;
      nxt_state.div_s1  = clock_divide_select_i;
      nxt_state.div_s2  = state_ff.div_s1;
      nxt_state.byp_s1  = filter_bypass_i;
      nxt_state.byp_s2  = state_ff.byp_s1;
      nxt_state.fs_s1   = frame_sync_format_i;
      nxt_state.fs_s2   = state_ff.fs_s1;
      nxt_state.sync_s1 = ext_sync_i;
      nxt_state.sync_s2 = state_ff.sync_s1;
      nxt_state.bits_s1 = mod_bits_i;
      nxt_state.bits_s2 = state_ff.bits_s1;
      nxt_state.sync_d  = state_ff.sync_s2;
      sync_rise = state_ff.sync_s2 && !state_ff.sync_d;
      nxt_state.word_vld   = 1'b0;
      nxt_state.mod_strobe = 1'b0;
      // one shared divider sets the sampling instant of all channels
      if (state_ff.clk_cnt >= mod_div(state_ff.prof_s2, state_ff.div_s2)
                              - 6'h1) begin
         nxt_state.clk_cnt = '0;
         mod_tick = 1'b1;
      end else begin
         nxt_state.clk_cnt = state_ff.clk_cnt + 6'h1;
      end
      // a profile change or external sync restarts every filter together
      if (sync_rise || state_ff.prof_s2 != state_ff.last_prof) begin
         nxt_state.last_prof = state_ff.prof_s2;
         nxt_state.clk_cnt   = '0;
         nxt_state.samp_cnt  = '0;
         nxt_state.integ     = '0;
         nxt_state.comb_d    = '0;
         nxt_state.periods   = '0;
         nxt_state.settled   = 1'b0;
      end else if (mod_tick) begin
         nxt_state.mod_strobe = 1'b1;
         nxt_state.raw_bits   = state_ff.bits_s2;
         frame_end = (state_ff.samp_cnt == osr(state_ff.prof_s2) - 8'h1);
         nxt_state.samp_cnt = frame_end ? 8'h0
                                        : state_ff.samp_cnt + 8'h1;
         for (int ch = 0; ch < `ODF_NUM_CH; ch++) begin
            // third-order sinc: linear phase, nulls at multiples of rate
            nxt_state.integ[ch][0] = state_ff.integ[ch][0]
               + {{(`ODF_ACC_W-1){1'b0}}, state_ff.bits_s2[ch]};
            nxt_state.integ[ch][1] = state_ff.integ[ch][1]
               + state_ff.integ[ch][0];
            nxt_state.integ[ch][2] = state_ff.integ[ch][2]
               + state_ff.integ[ch][1];
            if (frame_end) begin
               c0 = state_ff.integ[ch][2] - state_ff.comb_d[ch][0];
               c1 = c0 - state_ff.comb_d[ch][1];
               c2 = c1 - state_ff.comb_d[ch][2];
               nxt_state.comb_d[ch][0] = state_ff.integ[ch][2];
               nxt_state.comb_d[ch][1] = c0;
               nxt_state.comb_d[ch][2] = c1;
               words[ch*`ODF_WORD_W +: `ODF_WORD_W] =
                  clip_word(c2, state_ff.prof_s2);
            end
         end
         if (frame_end) begin
            nxt_state.word_set = words;
            nxt_state.word_vld = 1'b1;
            nxt_state.overrun  = !buf_in_ready;
            if (state_ff.periods != 8'hff) begin
               nxt_state.periods = state_ff.periods + 8'h1;
            end
            // settled flag counts whole periods since the last restart
            if (state_ff.periods + 8'h1 >=
                ((state_ff.prof_s2 == `ODF_PROF_HR) ? `ODF_SETTLE_128
                                                    : `ODF_SETTLE_64)) begin
               nxt_state.settled = 1'b1;
            end
         end
      end
      // the high speed profile only works with frame-sync reads
      nxt_state.fmt_err = (state_ff.prof_s2 == `ODF_PROF_HS)
                          && !state_ff.fs_s2;
      if (buf_out_valid && (!state_ff.valid_q || result_ready_i)) begin
         nxt_state.valid_q = 1'b1;
         nxt_state.data_q  = state_ff.byp_s2 ? '0 : buf_out_data;
      end else if (result_ready_i) begin
         nxt_state.valid_q = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= '0;
      end else if (clk_en_i) begin
         state_ff <= nxt_state;
      end
   end

   assign result_valid_o = state_ff.valid_q;
   assign result_data_o  = state_ff.data_q;
   assign mod_strobe_o   = state_ff.mod_strobe;
   assign raw_bits_o     = state_ff.raw_bits;
   assign settled_o      = state_ff.settled;
   assign format_error_o = state_ff.fmt_err;
   assign overrun_o      = state_ff.overrun;
   assign profile_o      = state_ff.last_prof;
endmodule

// File: logic/odf_consts.svh
// constants for the octal decimation filter block
`ifndef ODF_CONSTS_SVH
`define ODF_CONSTS_SVH
`define ODF_NUM_CH        8
`define ODF_WORD_W        24
`define ODF_ACC_W         32
`define ODF_OSR_64        8'h40
`define ODF_OSR_128       8'h80
`define ODF_RATIO_256     12'h100
`define ODF_RATIO_512     12'h200
`define ODF_RATIO_2560    12'ha00
`define ODF_MODDIV_4      6'h04
`define ODF_MODDIV_8      6'h08
`define ODF_MODDIV_40     6'h28
`define ODF_PROF_HS       2'h0
`define ODF_PROF_HR       2'h1
`define ODF_PROF_LP       2'h2
`define ODF_PROF_LS       2'h3
`define ODF_SETTLE_64     8'h4c
`define ODF_SETTLE_128    8'h4e
`define ODF_QUIET_PERIODS 8'h1e
`define ODF_POS_FULL      24'h7fffff
`define ODF_NEG_FULL      24'h800000
`define ODF_STAGES        3
`define ODF_SHIFT_64      5'h12
`define ODF_SHIFT_128     5'h15
`define ODF_ACC_POS_MAX   32'sh007fffff
`define ODF_ACC_NEG_MIN   32'shff800000
`endif

// File: logic/odf_pkg.sv
// types shared by the octal decimation filter block
`include "odf_consts.svh"
package odf_pkg;
   typedef enum logic [1:0] {
      ODF_HIGH_SPEED_PROFILE,
      ODF_HIGH_RESOLUTION_PROFILE,
      ODF_LOW_POWER_PROFILE,
      ODF_LOW_SPEED_PROFILE
   } odf_profile_t;
   typedef logic [`ODF_WORD_W-1:0] odf_word_t;
   typedef logic signed [`ODF_ACC_W-1:0] odf_acc_t;
endpackage

// File: logic/odf_skid_buf.sv
// two-entry valid/ready buffer for one set of eight result words
`include "odf_consts.svh"
module odf_skid_buf
   import odf_pkg::*;
(
   // clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 clk_en_i,
   // filling side
   input  wire logic                 in_valid_i,
   output logic                      in_ready_o,
   input  wire logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] in_data_i,
   // draining side
   output logic                      out_valid_o,
   input  wire logic                 out_ready_i,
   output logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] out_data_o
);
   typedef struct packed {
      logic [1:0][`ODF_NUM_CH*`ODF_WORD_W-1:0] mem;
      logic       wr_ptr;
      logic       rd_ptr;
      logic [1:0] count;
   } odf_buf_state_t;

   odf_buf_state_t state_ff;
   odf_buf_state_t nxt_state;
   logic           push;
   logic           pop;

   assign in_ready_o  = (state_ff.count != 2'h2);
   assign out_valid_o = (state_ff.count != 2'h0);
   assign out_data_o  = state_ff.mem[state_ff.rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      nxt_state = state_ff;
      if (push) begin
         nxt_state.mem[state_ff.wr_ptr] = in_data_i;
         nxt_state.wr_ptr = ~state_ff.wr_ptr;
      end
      if (pop) begin
         nxt_state.rd_ptr = ~state_ff.rd_ptr;
      end
      if (push && !pop) begin
         nxt_state.count = state_ff.count + 2'h1;
      end else if (pop && !push) begin
         nxt_state.count = state_ff.count - 2'h1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= '0;
      end else if (clk_en_i) begin
         state_ff <= nxt_state;
      end
   end
endmodule

// File: sim/odf_top_monitor.sv
// assertion checker bound to the filter core ports
`include "odf_consts.svh"
module odf_monitor
   import odf_pkg::*;
(
   // clock and reset
   input wire logic                 sys_clk_i,
   input wire logic                 reset_i,
   input wire logic                 clk_en_i,
   // configuration pins
   input wire logic [1:0]           profile_select_i,
   input wire logic                 clock_divide_select_i,
   input wire logic                 filter_bypass_i,
   input wire logic                 frame_sync_format_i,
   input wire logic                 ext_sync_i,
   input wire logic [`ODF_NUM_CH-1:0] mod_bits_i,
   // results and status
   input wire logic                 result_valid_o,
   input wire logic                 result_ready_i,
   input wire logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] result_data_o,
   input wire logic                 mod_strobe_o,
   input wire logic [`ODF_NUM_CH-1:0] raw_bits_o,
   input wire logic                 settled_o,
   input wire logic                 format_error_o,
   input wire logic                 overrun_o,
   input wire logic [1:0]           profile_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // the pins pass two sync flops, so a profile change lags a little
   chk_fmt_err_hs: assert property (
      format_error_o |-> profile_o == 2'h0 || $past(profile_o) == 2'h0)
      else $error("format error outside high speed profile");
   chk_result_stands: assert property (
      result_valid_o && !result_ready_i
      |=> result_valid_o && $stable(result_data_o))
      else $error("result set changed before it was taken");
   chk_strobe_spacing: assert property (
      mod_strobe_o && clk_en_i
      |=> (!mod_strobe_o || !clk_en_i) [*3])
      else $error("modulator ticks closer than four clocks");
   chk_hs_tick_rate: assert property (
      mod_strobe_o && profile_o == 2'h0 && clk_en_i
      |-> ##[1:8] (mod_strobe_o || profile_o != 2'h0 || !clk_en_i))
      else $error("high speed tick missing");
   chk_raw_on_tick: assert property (
      $changed(raw_bits_o) |-> mod_strobe_o)
      else $error("raw bits changed without a tick");
   chk_sync_clears: assert property (
      $rose(ext_sync_i) |-> ##[1:6] !settled_o)
      else $error("sync edge did not restart the filters");
   chk_profile_follow: assert property (
      (clk_en_i && $stable(profile_select_i)) [*4]
      |-> profile_o == profile_select_i)
      else $error("active profile does not follow the pins");
   chk_freeze_holds: assert property (
      !clk_en_i |=> $stable(settled_o) && $stable(raw_bits_o)
                    && $stable(result_data_o))
      else $error("state moved while clock enable low");
   chk_overrun_full: assert property (
      $rose(overrun_o) |-> result_valid_o)
      else $error("overrun raised with an empty buffer");
   chk_profile_clears: assert property (
      $changed(profile_o) |-> ##[0:4] !settled_o)
      else $error("profile change left settled high");
endmodule

bind odf_top odf_monitor u_mon (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
   .profile_select_i(profile_select_i),
   .clock_divide_select_i(clock_divide_select_i),
   .filter_bypass_i(filter_bypass_i),
   .frame_sync_format_i(frame_sync_format_i), .ext_sync_i(ext_sync_i),
   .mod_bits_i(mod_bits_i), .result_valid_o(result_valid_o),
   .result_ready_i(result_ready_i), .result_data_o(result_data_o),
   .mod_strobe_o(mod_strobe_o), .raw_bits_o(raw_bits_o),
   .settled_o(settled_o), .format_error_o(format_error_o),
   .overrun_o(overrun_o), .profile_o(profile_o));

// File: sim/odf_host_model.sv
// host that takes result sets and picks the serial format
`include "odf_consts.svh"
module odf_host_model
   import odf_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // bench controls
   input  wire logic        stall_i,
   input  wire logic        spi_style_i,
   // result handshake
   input  wire logic        valid_i,
   input  wire logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] data_i,
   output logic             ready_o,
   output logic             frame_sync_format_o,
   // what was taken
   output logic             take_o,
   output logic [15:0]      sets_o,
   output logic [`ODF_NUM_CH*`ODF_WORD_W-1:0] words_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // the host tells the core which format it reads with
   assign frame_sync_format_o = !spi_style_i;
   assign take_o = valid_i && ready_o;
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ready_o <= 1'b0;
         sets_o <= '0;
         words_o <= '0;
      end else begin
         ready_o <= !stall_i;
         if (take_o) begin
            sets_o <= sets_o + 16'h1;
            words_o <= data_i;
         end
      end
   end
endmodule

// File: sim/tb_odf_top.sv
// self-checking bench for the octal decimation filter core
`include "odf_consts.svh"
module tb_odf_top
   import odf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 80000;
   logic         sys_clk_i, reset_i, clk_en, div_sel, bypass, ext_sync;
   logic         stall, spi_style, rvalid, rready, strobe, settled;
   logic         fmt_err, overrun, fs_fmt, take;
   logic [1:0]   prof, prof_o;
   logic [7:0]   mod_bits, raw, r;
   logic [15:0]  sets, s0;
   logic [191:0] rdata, words;
   int           err_total, checks, cyc, g;
   logic [2:0]   tp [6] = '{3'h1, 3'h3, 3'h5, 3'h4, 3'h7, 3'h6};
   int           tick [6] = '{4, 4, 8, 4, 40, 8};

   always #2.5 sys_clk_i = ~sys_clk_i;

   odf_top DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
      .profile_select_i(prof), .clock_divide_select_i(div_sel),
      .filter_bypass_i(bypass), .frame_sync_format_i(fs_fmt),
      .ext_sync_i(ext_sync), .mod_bits_i(mod_bits), .result_valid_o(rvalid),
      .result_ready_i(rready), .result_data_o(rdata), .mod_strobe_o(strobe),
      .raw_bits_o(raw), .settled_o(settled), .format_error_o(fmt_err),
      .overrun_o(overrun), .profile_o(prof_o));
   odf_host_model u_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .stall_i(stall), .spi_style_i(spi_style), .valid_i(rvalid),
      .data_i(rdata), .ready_o(rready), .frame_sync_format_o(fs_fmt),
      .take_o(take), .sets_o(sets), .words_o(words));

   task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   // cycles between two events: strobe (s=0) or a taken set (s=1)
   task automatic gap(input bit s, output int n);
      n = 0;
      do @(negedge sys_clk_i); while ((s ? take : strobe) !== 1'b1);
      do begin
         @(negedge sys_clk_i);
         n++;
      end while ((s ? take : strobe) !== 1'b1);
   endtask

   // words only land in the host one edge after the take
   task automatic next_set;
      do @(negedge sys_clk_i); while (take !== 1'b1);
      @(negedge sys_clk_i);
   endtask

   function automatic logic [191:0] full(input logic [7:0] b);
      for (int n = 0; n < 8; n++)
         full[24*n +: 24] = b[n] ? `ODF_POS_FULL : `ODF_NEG_FULL;
   endfunction

   // a hang anywhere ends the run through the same report
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         final_report();
      end
   end

   initial begin
      {sys_clk_i, clk_en, div_sel, bypass, ext_sync} = 5'h0c;
      {stall, spi_style, prof, err_total, checks, cyc} = '0;
      reset_i = 1'b1;
      mod_bits = 8'h55;
      cycles(4);
      reset_i = 1'b0;
      cycles(10);
      chk(prof_o, 2'h0);
      chk(fmt_err, 1'b0);
      repeat (2) gap(0, g);
      chk(g, 4);
      repeat (2) gap(1, g);
      chk(g, 256);
      while (settled !== 1'b1) @(negedge sys_clk_i);
      chk((sets >= 16'd75) && (sets <= 16'd77), 1'b1);
      next_set();
      chk(words, full(8'h55));
      r = raw;
      clk_en = 1'b0;
      // new pin bits must not reach the frozen synchroniser
      mod_bits = 8'haa;
      cycles(20);
      chk(raw, r);
      mod_bits = 8'h55;
      clk_en = 1'b1;
      // hold the host off over five frames: output, two buffered, dropped
      stall = 1'b1;
      cycles(5 * 256);
      chk(overrun, 1'b1);
      s0 = sets;
      stall = 1'b0;
      cycles(8);
      chk(words, full(8'h55));
      chk((sets - s0) >= 16'h3, 1'b1);
      ext_sync = 1'b1;
      cycles(8);
      chk(settled, 1'b0);
      ext_sync = 1'b0;
      bypass = 1'b1;
      mod_bits = 8'ha5;
      repeat (3) next_set();
      chk(words, '0);
      gap(0, g);
      chk(raw, 8'ha5);
      bypass = 1'b0;
      spi_style = 1'b1;
      for (int i = 0; i < 6; i++) begin
         {prof, div_sel} = tp[i];
         repeat (2) gap(0, g);
         chk(g, tick[i]);
         repeat (2) gap(1, g);
         chk(g, tick[i] * ((prof == 2'h1) ? 128 : 64));
         chk(prof_o, prof);
         chk(fmt_err, prof == 2'h0);
         chk(settled, 1'b0);
      end
      final_report();
   end
endmodule
